// ---- pkg/qpc_params.svh ----
// Register offsets, field positions and reset values of the position counter
`ifndef QPC_PARAMS_SVH
`define QPC_PARAMS_SVH
`define CTRL_OFFSET 12'h000
`define COUNT_OFFSET 12'h004
`define STATUS_OFFSET 12'h008
`define CTRL_PREC_LSB 0
`define CTRL_PREC_MSB 1
`define CTRL_RESET_EACH 2
`define CTRL_INVERT_RESET 3
`define CTRL_ENABLE 4
`define CTRL_RESET_VALUE 32'h0000_0014
`define COUNT_CLEAR_VALUE 32'h0000_0000
`endif

// ---- pkg/qpc_pkg.sv ----
// Types of the quadrature position counter
package qpc_pkg;
  typedef enum logic [1:0] {
    PREC_SINGLE = 2'h0,
    PREC_DOUBLE = 2'h1,
    PREC_QUAD = 2'h2
  } precision_t;
  typedef struct packed {
    logic enable;
    logic invert_reset;
    logic reset_each;
    precision_t precision;
  } ctrl_t;
  typedef struct packed {
    logic sig;
    logic dir;
    logic rst;
  } enc_pins_t;
endpackage : qpc_pkg

// ---- core/quadrature_position_counter.sv ----
// Quadrature position counter with APB register access
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "qpc_params.svh"
module quadrature_position_counter
  import qpc_pkg::*;
#(
  parameter int COUNT_W = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic enc_sig,
  input wire logic enc_dir,
  input wire logic enc_rst
);

  // Two-stage synchronisers for the three encoder pins
  enc_pins_t sync1, sync2, prev;
  enc_pins_t next_sync1, next_sync2, next_prev;
  always_comb begin
    next_sync1 = '{sig: enc_sig, dir: enc_dir, rst: enc_rst};
    next_sync2 = sync1;
    next_prev = sync2;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= '0;
      sync2 <= '0;
      prev <= '0;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      prev <= next_prev;
    end
  end

  // Register state
  ctrl_t ctrl, next_ctrl;
  logic [COUNT_W-1:0] count, next_count;
  logic [31:0] prdata_q, next_prdata;
  logic [15:0] pulse_cnt, next_pulse_cnt;

  wire logic access = psel && penable;
  wire logic wr = access && pwrite;
  // Read data is captured in the setup cycle so that it comes from a flop
  wire logic rd_setup = psel && !penable && !pwrite;

  function automatic logic known_addr(input logic [11:0] a);
    known_addr = (a == `CTRL_OFFSET) || (a == `COUNT_OFFSET) ||
      (a == `STATUS_OFFSET);
  endfunction : known_addr

  // Reset input active level after optional inversion
  logic rst_active, rst_active_prev, rst_pulse;
  logic sig_rise, sig_fall, dir_edge, sig_edge;
  logic fwd, step;
  always_comb begin
    rst_active = ctrl.invert_reset ? !sync2.rst : sync2.rst;
    rst_active_prev = ctrl.invert_reset ? !prev.rst : prev.rst;
    rst_pulse = rst_active && !rst_active_prev;
    sig_rise = sync2.sig && !prev.sig;
    sig_fall = !sync2.sig && prev.sig;
    sig_edge = sig_rise || sig_fall;
    dir_edge = sync2.dir != prev.dir;
    // Four-state step direction from old and new {sig,dir} states
    fwd = sig_edge ? (sync2.sig != sync2.dir) : (sync2.sig == sync2.dir);
    case (ctrl.precision)
      PREC_SINGLE: step = sig_rise;
      PREC_DOUBLE: step = sig_edge;
      PREC_QUAD: step = sig_edge || dir_edge;
      default: step = sig_rise;
    endcase
    // Both inputs moving at once is an illegal skip, ignored
    if (sig_edge && dir_edge) begin
      step = 1'b0;
    end
  end

  always_comb begin
    next_ctrl = ctrl;
    next_count = count;
    next_pulse_cnt = pulse_cnt;
    next_prdata = prdata_q;
    if (wr && paddr == `CTRL_OFFSET) begin
      next_ctrl = ctrl_t'(pwdata[`CTRL_ENABLE:0]);
    end
    if (rst_pulse) begin
      next_pulse_cnt = pulse_cnt + 16'h0001;
    end
    if (rst_active) begin
      next_count = COUNT_W'(`COUNT_CLEAR_VALUE);
    end else if (rst_pulse && ctrl.reset_each) begin
      next_count = COUNT_W'(`COUNT_CLEAR_VALUE);
    end else if (ctrl.enable && step) begin
      next_count = fwd ? count + 1'b1 : count - 1'b1;
    end
    if (wr && paddr == `COUNT_OFFSET) begin
      next_count = pwdata[COUNT_W-1:0];
    end
    if (rd_setup) begin
      case (paddr)
        `CTRL_OFFSET: next_prdata = {27'h0, ctrl};
        `COUNT_OFFSET: next_prdata = 32'(count);
        `STATUS_OFFSET: next_prdata = {13'h0, sync2, pulse_cnt};
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= ctrl_t'(5'(`CTRL_RESET_VALUE));
      count <= '0;
      pulse_cnt <= 16'h0000;
      prdata_q <= 32'h0000_0000;
    end else begin
      ctrl <= next_ctrl;
      count <= next_count;
      pulse_cnt <= next_pulse_cnt;
      prdata_q <= next_prdata;
    end
  end

  // Zero-wait reads: data captured at the setup edge stands in the access
  always_comb begin
    pready = 1'b1;
    pslverr = access && !known_addr(paddr);
    prdata = prdata_q;
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  single_default_a: assert property ($rose(presetn) |-> ctrl.precision == PREC_SINGLE) else $error("precision not single after reset");
  single_fall_a: assert property ((ctrl.precision == PREC_SINGLE && sig_fall && !rst_active && !rst_pulse && !(wr && paddr == `COUNT_OFFSET)) |=> $stable(count)) else $error("single counted a fall");
  single_rise_a: assert property ((ctrl.precision == PREC_SINGLE && ctrl.enable && sig_rise && !dir_edge && !rst_active && !(wr && paddr == `COUNT_OFFSET)) |=> count != $past(count)) else $error("single missed a rise");
  double_edge_a: assert property ((ctrl.precision == PREC_DOUBLE && ctrl.enable && sig_fall && !dir_edge && !rst_active && !(wr && paddr == `COUNT_OFFSET)) |=> count != $past(count)) else $error("double missed a fall");
  quad_dir_a: assert property ((ctrl.precision == PREC_QUAD && ctrl.enable && dir_edge && !sig_edge && !rst_active && !(wr && paddr == `COUNT_OFFSET)) |=> count != $past(count)) else $error("quad missed a dir edge");
  hold_zero_a: assert property ((rst_active && !(wr && paddr == `COUNT_OFFSET)) |=> count == '0) else $error("count not cleared by reset level");
  up_lead_a: assert property ((ctrl.enable && sig_rise && !sync2.dir && !dir_edge && !rst_active && ctrl.precision != PREC_QUAD && !(wr && paddr == `COUNT_OFFSET)) |=> count == $past(count) + 1'b1) else $error("lead did not count up");
  pulse_clear_a: assert property ((rst_pulse && ctrl.reset_each && !(wr && paddr == `COUNT_OFFSET)) |=> count == '0) else $error("pulse did not clear");

  // Steps of a register read: setup on the count register, then access
  sequence count_setup_s;
    psel && !penable && !pwrite && paddr == `COUNT_OFFSET;
  endsequence
  sequence access_s;
    psel && penable && pready;
  endsequence

  read_count_a: assert property (count_setup_s ##1 access_s |-> prdata == $past(32'(count))) else $error("read data not the count");
  sync_delay_a: assert property (sync2 == $past({enc_sig, enc_dir, enc_rst}, 2)) else $error("pins not two flops deep");
  down_lag_a: assert property ((ctrl.enable && sig_rise && sync2.dir && !dir_edge && !rst_active && ctrl.precision != PREC_QUAD && !(wr && paddr == `COUNT_OFFSET)) |=> count == $past(count) - 1'b1) else $error("lag did not count down");
  invert_hold_a: assert property ((ctrl.invert_reset && !sync2.rst && !(wr && paddr == `COUNT_OFFSET)) |=> count == '0) else $error("low level did not clear");

endmodule : quadrature_position_counter
`default_nettype wire

// ---- sim/enc_model.sv ----
// Encoder partner: quadrature signal, direction and reset pins
`timescale 1ns/1ps
`default_nettype none
module enc_model
  import qpc_pkg::*;
(
  input wire logic pclk,
  input wire logic step,
  input wire logic up,
  input wire logic rst,
  output var enc_pins_t pins
);
  logic [1:0] ph = 2'h0;
  always @(posedge pclk) begin
    if (step) ph <= up ? ph + 2'h1 : ph - 2'h1;
  end
  // Order 00,10,11,01: signal leads direction when moving up
  assign pins = {ph[0] ^ ph[1], ph[1], rst};
endmodule : enc_model
`default_nettype wire

// ---- sim/quadrature_position_counter_test.sv ----
// Self-checking bench of the quadrature position counter
`timescale 1ns/1ps
`default_nettype none
`include "qpc_params.svh"
module quadrature_position_counter_test
  import qpc_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, step = 1'b0, up = 1'b0, rst = 1'b0, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  enc_pins_t pins;
  int failures = 0, tests_run = 0, n;
  always #2 pclk = ~pclk;
  enc_model enc_model_i (.pclk(pclk), .step(step), .up(up), .rst(rst),
    .pins(pins));
  quadrature_position_counter quadrature_position_counter_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .enc_sig(pins.sig), .enc_dir(pins.dir),
    .enc_rst(pins.rst));
  task print_verdict;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task rd(input logic [11:0] a, input logic [32:0] x);
    exp_q.push_back(x);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task mv(input int k, input logic u);
    repeat (k) begin
      step <= 1'b1;
      up <= u;
      @(posedge pclk);
      step <= 1'b0;
      repeat (4) @(posedge pclk);
    end
  endtask : mv
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      e = exp_q.pop_front();
      tests_run++;
      if ({pslverr, prdata} !== e) begin
        failures++;
        $display("unexpected read: expected %h seen %h", e, {pslverr, prdata});
      end
    end
  end
  initial begin
    #200000;
    failures++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'hc4e52364));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`CTRL_OFFSET, {1'b0, `CTRL_RESET_VALUE});
    rd(12'h00c, 33'h1_0000_0000);
    $display("register test done");
    for (int p = 0; p < 3; p++) begin
      n = $urandom_range(4, 1);
      apb(1'b1, `CTRL_OFFSET, 32'h10 | 32'(p));
      apb(1'b1, `COUNT_OFFSET, 32'h0);
      mv(4 * n, 1'b1);
      mv(4, 1'b0);
      rd(`COUNT_OFFSET, {1'b0, 32'(n - 1) << p});
      $display("precision test %0d done", p);
    end
    apb(1'b1, `CTRL_OFFSET, 32'h16);
    mv(4, 1'b1);
    rst <= 1'b1;
    mv(4, 1'b1);
    rst <= 1'b0;
    repeat (4) @(posedge pclk);
    rd(`COUNT_OFFSET, 33'h0);
    mv(4, 1'b1);
    rd(`COUNT_OFFSET, 33'h4);
    $display("reset test done");
    apb(1'b1, `CTRL_OFFSET, 32'h1e);
    rd(`COUNT_OFFSET, 33'h0);
    rst <= 1'b1;
    mv(4, 1'b1);
    rd(`COUNT_OFFSET, 33'h4);
    $display("inverted reset test done");
    print_verdict();
  end
endmodule : quadrature_position_counter_test
`default_nettype wire
